// ### logic/ext_bus_master.sv
`timescale 1ns/1ps
`default_nettype none
module ext_bus_master #(
  parameter int aw = ext_bus_pkg::addr_width,
  parameter int dw = ext_bus_pkg::data_width
) (
  input wire logic clk_in, // system clock
  input wire logic rst_in, // async reset, active high
  input wire logic req_valid_in, // access request from core
  input wire logic [1:0] req_kind_in, // ext_bus_pkg kind code
  input wire logic req_fetch_in, // memory read is an opcode fetch
  input wire logic [aw-1:0] req_addr_in, // access address
  input wire logic [dw-1:0] req_wdata_in, // write data
  output logic req_ready_out, // request was taken at the previous clock edge
  output logic done_out, // access finished pulse
  output logic [dw-1:0] rdata_out, // captured read data
  output logic [aw-1:0] addr_out, // address pins out
  output logic addr_oe_n_out, // address drive enable, low drives
  input wire logic [aw-1:0] addr_in, // address pins in
  output logic [dw-1:0] data_out, // data pins out
  output logic data_oe_n_out, // data drive enable, low drives
  input wire logic [dw-1:0] data_in, // data pins in
  output logic io_space_req_n_out, // io request pin out
  output logic mem_space_req_n_out, // memory request pin out
  output logic space_req_oe_n_out, // request pins enable, low drives
  input wire logic io_space_req_n_in, // io request pin in
  input wire logic mem_space_req_n_in, // memory request pin in
  output logic rd_n_out, // read strobe
  output logic wr_n_out, // write strobe
  output logic opcode_fetch_n_out, // fetch indicator
  output logic strobe_oe_n_out, // strobe enable, low drives
  input wire logic wait_n_in, // wait pin
  input wire logic bus_release_request_n_in, // bus request pin
  output logic bus_granted_n_out, // bus acknowledge pin
  output logic [aw-1:0] ext_addr_out // address seen while granted
);
  import ext_bus_pkg::*;
  logic wait_n;
  logic breq_n;
  pin_sync wait_sync (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .pin_in(wait_n_in),
    .level_out(wait_n)
  );
  pin_sync breq_sync (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .pin_in(bus_release_request_n_in),
    .level_out(breq_n)
  );
  state_type state, next_state;
  logic [1:0] kind, next_kind;
  logic [2:0] settle, next_settle;
  logic [aw-1:0] addr, next_addr;
  logic [dw-1:0] wdata, next_wdata;
  logic [dw-1:0] rdata, next_rdata;
  logic ready, next_ready;
  logic done, next_done;
  logic addr_oe_n, next_addr_oe_n;
  logic data_oe_n, next_data_oe_n;
  logic sp_oe_n, next_sp_oe_n;
  logic io_n, next_io_n;
  logic mem_n, next_mem_n;
  logic rd_n, next_rd_n;
  logic wr_n, next_wr_n;
  logic fet_n, next_fet_n;
  logic st_oe_n, next_st_oe_n;
  logic gnt_n, next_gnt_n;
  logic [aw-1:0] ext_addr, next_ext_addr;

  function automatic logic is_write(input logic [1:0] k);
    return (k == kind_mem_write) || (k == kind_io_write);
  endfunction : is_write
  function automatic logic is_io(input logic [1:0] k);
    return (k == kind_io_read) || (k == kind_io_write);
  endfunction : is_io

  always_comb begin
    next_state = state;
    next_kind = kind;
    next_settle = (settle == wait_settle) ? settle : settle + 3'h1;
    next_addr = addr;
    next_wdata = wdata;
    next_rdata = rdata;
    next_ready = 1'h0;
    next_done = 1'h0;
    next_addr_oe_n = addr_oe_n;
    next_data_oe_n = data_oe_n;
    next_sp_oe_n = sp_oe_n;
    next_io_n = io_n;
    next_mem_n = mem_n;
    next_rd_n = rd_n;
    next_wr_n = wr_n;
    next_fet_n = fet_n;
    next_st_oe_n = st_oe_n;
    next_gnt_n = gnt_n;
    next_ext_addr = ext_addr;
    case (state)
      st_idle: begin
        if (!breq_n) begin
          // release every output before acknowledging
          next_addr_oe_n = 1'h1;
          next_data_oe_n = 1'h1;
          next_sp_oe_n = 1'h1;
          next_st_oe_n = 1'h1;
          next_state = st_release;
        end else if (req_valid_in) begin
          next_ready = 1'h1;
          next_kind = req_kind_in;
          next_addr = req_addr_in;
          next_wdata = req_wdata_in;
          next_addr_oe_n = 1'h0;
          next_io_n = !is_io(req_kind_in);
          next_mem_n = is_io(req_kind_in);
          next_fet_n = !(req_fetch_in && (req_kind_in == kind_mem_read));
          next_data_oe_n = !is_write(req_kind_in);
          next_state = st_setup;
        end
      end
      st_setup: begin
        next_rd_n = is_write(kind);
        next_wr_n = !is_write(kind);
        next_state = st_strobe;
      end
      st_strobe: begin
        // outputs hold while wait is low; a wait level left high by the last
        // access is stale until the synchroniser has refreshed it
        if (wait_n && (settle == wait_settle)) begin
          if (!is_write(kind)) begin
            next_rdata = data_in;
          end
          next_done = 1'h1;
          next_settle = '0;
          next_rd_n = 1'h1;
          next_wr_n = 1'h1;
          next_io_n = 1'h1;
          next_mem_n = 1'h1;
          next_fet_n = 1'h1;
          next_data_oe_n = 1'h1;
          next_state = st_idle;
        end
      end
      st_release: begin
        next_gnt_n = 1'h0;
        next_state = st_granted;
      end
      st_granted: begin
        next_ext_addr = addr_in;
        if (breq_n) begin
          next_gnt_n = 1'h1;
          next_addr_oe_n = 1'h0;
          next_sp_oe_n = 1'h0;
          next_st_oe_n = 1'h0;
          next_state = st_idle;
        end
      end
      default: begin
        next_state = st_idle;
      end
    endcase
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state <= st_idle;
      kind <= kind_mem_read;
      settle <= wait_settle;
      addr <= '0;
      wdata <= '0;
      rdata <= '0;
      ready <= 1'h0;
      done <= 1'h0;
      addr_oe_n <= 1'h0;
      data_oe_n <= 1'h1;
      sp_oe_n <= 1'h0;
      io_n <= 1'h1;
      mem_n <= 1'h1;
      rd_n <= 1'h1;
      wr_n <= 1'h1;
      fet_n <= 1'h1;
      st_oe_n <= 1'h0;
      gnt_n <= 1'h1;
      ext_addr <= '0;
    end else begin
      state <= next_state;
      kind <= next_kind;
      settle <= next_settle;
      addr <= next_addr;
      wdata <= next_wdata;
      rdata <= next_rdata;
      ready <= next_ready;
      done <= next_done;
      addr_oe_n <= next_addr_oe_n;
      data_oe_n <= next_data_oe_n;
      sp_oe_n <= next_sp_oe_n;
      io_n <= next_io_n;
      mem_n <= next_mem_n;
      rd_n <= next_rd_n;
      wr_n <= next_wr_n;
      fet_n <= next_fet_n;
      st_oe_n <= next_st_oe_n;
      gnt_n <= next_gnt_n;
      ext_addr <= next_ext_addr;
    end
  end

  assign req_ready_out = ready;
  assign done_out = done;
  assign rdata_out = rdata;
  assign addr_out = addr;
  assign addr_oe_n_out = addr_oe_n;
  assign data_out = wdata;
  assign data_oe_n_out = data_oe_n;
  assign io_space_req_n_out = io_n;
  assign mem_space_req_n_out = mem_n;
  assign space_req_oe_n_out = sp_oe_n;
  assign rd_n_out = rd_n;
  assign wr_n_out = wr_n;
  assign opcode_fetch_n_out = fet_n;
  assign strobe_oe_n_out = st_oe_n;
  assign bus_granted_n_out = gnt_n;
  assign ext_addr_out = ext_addr;
endmodule : ext_bus_master
`default_nettype wire

// ### pkg/ext_bus_pkg.sv
package ext_bus_pkg;
  localparam int addr_width = 24;
  localparam int data_width = 8;
  localparam logic [1:0] kind_mem_read = 2'h0;
  localparam logic [1:0] kind_mem_write = 2'h1;
  localparam logic [1:0] kind_io_read = 2'h2;
  localparam logic [1:0] kind_io_write = 2'h3;
  localparam logic [1:0] sync_reset = 2'h3;
  localparam logic [1:0] sync_reset_val = 2'h3;
  localparam int min_reset_cycles = 3;
  // cycles after an access ends before the synchronised wait shows the pin again
  localparam logic [2:0] wait_settle = 3'h4;
  typedef enum logic [4:0] {
    st_idle = 5'h01,
    st_setup = 5'h02,
    st_strobe = 5'h04,
    st_release = 5'h08,
    st_granted = 5'h10
  } state_type;
endpackage : ext_bus_pkg

// ### logic/pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
  input wire logic clk_in, // system clock
  input wire logic rst_in, // async reset
  input wire logic pin_in, // raw pin
  output logic level_out // filtered level
);
  import ext_bus_pkg::*;
  logic [2:0] stage;
  logic [2:0] next_stage;
  logic level;
  logic next_level;
  always_comb begin
    next_stage = {stage[1:0], pin_in};
    next_level = (stage[2] == stage[1]) ? stage[2] : level;
  end
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      stage <= 3'h7;
      level <= 1'h1;
    end else begin
      stage <= next_stage;
      level <= next_level;
    end
  end
  assign level_out = level;
endmodule : pin_sync
`default_nettype wire

// ### test/ext_bus_master_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module ext_bus_checker #(
  parameter int aw = 24
) (
  input wire logic clk_in, rst_in, req_ready_out, done_out, wait_n_in,
  input wire logic [aw-1:0] addr_out,
  input wire logic addr_oe_n_out, data_oe_n_out, io_space_req_n_out, mem_space_req_n_out,
  input wire logic space_req_oe_n_out, rd_n_out, wr_n_out, opcode_fetch_n_out,
  input wire logic strobe_oe_n_out, bus_granted_n_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  sequence s_strobe;
    !rd_n_out || !wr_n_out;
  endsequence
  a_data_drive:
    assert property (!data_oe_n_out |-> rd_n_out && bus_granted_n_out) else $error("data drive");
  a_io_space:
    assert property (!io_space_req_n_out |-> mem_space_req_n_out && opcode_fetch_n_out)
      else $error("io request mixed");
  a_fetch_pair:
    assert property (!opcode_fetch_n_out |-> !mem_space_req_n_out && wr_n_out) else $error("fetch");
  a_read_strobe:
    assert property (!rd_n_out |-> wr_n_out && (io_space_req_n_out ^ mem_space_req_n_out))
      else $error("read strobe");
  a_write_strobe:
    assert property (!wr_n_out |-> !data_oe_n_out && (io_space_req_n_out ^ mem_space_req_n_out))
      else $error("write strobe");
  a_ready_strobe:
    assert property (req_ready_out |=> s_strobe) else $error("no strobe after take");
  a_grant_float:
    assert property (!bus_granted_n_out |-> space_req_oe_n_out && strobe_oe_n_out
      && addr_oe_n_out && data_oe_n_out) else $error("pins driven while granted");
  a_grant_order:
    assert property ($fell(bus_granted_n_out) |-> $past(strobe_oe_n_out) && $past(addr_oe_n_out))
      else $error("grant before release");
  a_wait_hold:
    assert property (s_strobe ##1 s_strobe |-> $stable(addr_out) && $stable(io_space_req_n_out)
      && $stable(mem_space_req_n_out)) else $error("pins moved in wait");
  a_wait_stretch:
    assert property (!wait_n_in [*6] |-> !done_out) else $error("done during wait");
endmodule : ext_bus_checker
bind ext_bus_master ext_bus_checker #(.aw(aw)) u_chk (.clk_in, .rst_in, .req_ready_out,
  .done_out, .wait_n_in, .addr_out, .addr_oe_n_out, .data_oe_n_out, .io_space_req_n_out,
  .mem_space_req_n_out, .space_req_oe_n_out, .rd_n_out, .wr_n_out, .opcode_fetch_n_out,
  .strobe_oe_n_out, .bus_granted_n_out);
`default_nettype wire

// ### test/ext_bus_device.sv
`timescale 1ns/1ps
`default_nettype none
module ext_bus_device (
  input wire logic clk_in, slow_in, // slow: wait held until strobe ran wait_len_in
  input wire logic [3:0] wait_len_in,
  input wire logic [23:0] addr_out,
  input wire logic [7:0] data_out,
  input wire logic data_oe_n_out, io_space_req_n_out, mem_space_req_n_out,
  input wire logic rd_n_out, wr_n_out, strobe_oe_n_out,
  output logic [7:0] data_in, // resolved data pins
  output logic wait_n_in // wait pin
);
  logic [7:0] mem [256];
  logic [7:0] io [256];
  logic [7:0] last = 8'h00;
  logic [3:0] cnt = 4'h0;
  wire logic rd = !strobe_oe_n_out && !rd_n_out;
  wire logic wr = !strobe_oe_n_out && !wr_n_out;
  // io and memory are separate spaces, chosen by the request pins
  always_comb begin
    if (!data_oe_n_out) data_in = data_out;
    else if (rd) data_in = io_space_req_n_out ? mem[addr_out[7:0]] : io[addr_out[7:0]];
    else data_in = ~last;
  end
  always @(posedge clk_in) begin
    last <= data_in;
    cnt <= (rd || wr) ? cnt + {3'h0, cnt != wait_len_in} : 4'h0;
    if (wr && !mem_space_req_n_out) mem[addr_out[7:0]] <= data_out;
    if (wr && !io_space_req_n_out) io[addr_out[7:0]] <= data_out;
  end
  assign wait_n_in = !slow_in || ((rd || wr) && cnt == wait_len_in);
endmodule : ext_bus_device
`default_nettype wire

// ### test/test_external_memory_io_bus_master.sv
`timescale 1ns/1ps
`default_nettype none
module test_external_memory_io_bus_master;
  import ext_bus_pkg::*;
  logic clk_in = 1'b0, rst_in = 1'b1, req_valid_in = 1'b0, req_fetch_in = 1'b0;
  logic slow = 1'b0, brq_n = 1'b1;
  logic [1:0] req_kind_in = 2'h0;
  logic [3:0] wlen = 4'h0;
  logic [23:0] req_addr_in = 24'h0, xa = 24'h0, addr_out, ext_addr_out;
  logic [7:0] req_wdata_in = 8'h0, data_in, data_out, rdata_out;
  logic req_ready_out, done_out, addr_oe_n_out, data_oe_n_out, io_space_req_n_out;
  logic mem_space_req_n_out, space_req_oe_n_out, rd_n_out, wr_n_out, opcode_fetch_n_out;
  logic strobe_oe_n_out, wait_n_in, bus_granted_n_out;
  int n_errors = 0, num_checks = 0, cyc = 0;
  always #2.5 clk_in = ~clk_in;
  ext_bus_master uut (.clk_in, .rst_in, .req_valid_in, .req_kind_in, .req_fetch_in,
    .req_addr_in, .req_wdata_in, .req_ready_out, .done_out, .rdata_out, .addr_out,
    .addr_oe_n_out, .addr_in(addr_oe_n_out ? xa : addr_out), .data_out, .data_oe_n_out,
    .data_in, .io_space_req_n_out, .mem_space_req_n_out, .space_req_oe_n_out,
    .io_space_req_n_in(io_space_req_n_out | space_req_oe_n_out),
    .mem_space_req_n_in(mem_space_req_n_out | space_req_oe_n_out), .rd_n_out, .wr_n_out,
    .opcode_fetch_n_out, .strobe_oe_n_out, .wait_n_in, .bus_release_request_n_in(brq_n),
    .bus_granted_n_out, .ext_addr_out);
  ext_bus_device dev (.clk_in, .slow_in(slow), .wait_len_in(wlen), .addr_out, .data_out,
    .data_oe_n_out, .io_space_req_n_out, .mem_space_req_n_out, .rd_n_out, .wr_n_out,
    .strobe_oe_n_out, .data_in, .wait_n_in);
  task automatic complete_run;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : complete_run
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_errors++;
      complete_run();
    end
  end
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // one access; n returns the cycles from ready to done
  task automatic access(input logic [1:0] k, input logic f, input logic [23:0] a,
      input logic [7:0] d, output logic [7:0] r, output int n);
    req_kind_in <= k;
    req_fetch_in <= f;
    req_addr_in <= a;
    req_wdata_in <= d;
    req_valid_in <= 1'b1;
    for (n = 0; n < 20 && req_ready_out !== 1'b1; n++) @(posedge clk_in);
    req_valid_in <= 1'b0;
    chk(req_ready_out, 1'b1);
    chk(addr_out, a);
    chk(data_out, d);
    chk(io_space_req_n_out, !k[1]);
    chk(mem_space_req_n_out, k[1]);
    chk(opcode_fetch_n_out, !f);
    chk(data_oe_n_out, !k[0]);
    @(posedge clk_in);
    chk({rd_n_out, wr_n_out}, k[0] ? 2'h2 : 2'h1);
    for (n = 1; n < 40 && done_out !== 1'b1; n++) @(posedge clk_in);
    chk(done_out, 1'b1);
    r = rdata_out;
  endtask : access
  task automatic t_kinds;
    logic [7:0] r;
    int n;
    access(kind_mem_write, 1'b0, 24'h000012, 8'ha5, r, n);
    chk(n, 2);
    access(kind_io_write, 1'b0, 24'h000012, 8'h3c, r, n);
    access(kind_mem_read, 1'b0, 24'h000012, 8'h00, r, n);
    chk(r, 8'ha5);
    access(kind_io_read, 1'b0, 24'h000012, 8'h00, r, n);
    chk(r, 8'h3c);
    access(kind_mem_read, 1'b1, 24'h000012, 8'h00, r, n);
    chk(r, 8'ha5);
  endtask : t_kinds
  task automatic t_wait;
    logic [7:0] r;
    int n;
    slow <= 1'b1;
    wlen <= 4'h5;
    repeat (5) @(posedge clk_in);
    access(kind_io_write, 1'b0, 24'h000040, 8'hc3, r, n);
    chk(n >= 7, 1'b1);
    access(kind_io_read, 1'b0, 24'h000040, 8'h00, r, n);
    chk(n >= 7, 1'b1);
    chk(r, 8'hc3);
    slow <= 1'b0;
  endtask : t_wait
  task automatic t_grant;
    logic [7:0] r;
    int n;
    brq_n <= 1'b0;
    xa <= 24'habcdef;
    for (n = 0; n < 10 && bus_granted_n_out !== 1'b0; n++) @(posedge clk_in);
    chk(bus_granted_n_out, 1'b0);
    chk({addr_oe_n_out, data_oe_n_out, space_req_oe_n_out, strobe_oe_n_out}, 4'hf);
    req_valid_in <= 1'b1;
    repeat (6) begin
      @(posedge clk_in);
      chk(req_ready_out, 1'b0);
    end
    chk(ext_addr_out, 24'habcdef);
    brq_n <= 1'b1;
    access(kind_mem_read, 1'b0, 24'h000012, 8'h00, r, n);
    chk(r, 8'ha5);
  endtask : t_grant
  initial begin
    repeat (5) @(posedge clk_in);
    chk({bus_granted_n_out, data_oe_n_out, rd_n_out, wr_n_out}, 4'hf);
    rst_in <= 1'b0;
    @(posedge clk_in);
    t_kinds();
    t_wait();
    t_grant();
    complete_run();
  end
endmodule : test_external_memory_io_bus_master
`default_nettype wire
